// ---- rtl/tsq_regs.sv ----
/*
 software registers of the trigger sequencer step queue and a minimal step
 walker that advances the queue pointer and applies the copy command.
 assumes a master that holds strobes for one cycle, never both at once.
*/
// How it works
// - counter-1 limit register, sixteen bits, loop count
// - hold register copied out by copy command
// - registers other than control read-only while enabled and started
// - five-bit pointer, upper bits read zero
// - eight queue words, two command bytes each
// - queue contents survive every reset
// - step lasts delay limit plus four clocks
`timescale 1ns/10ps
module tsq_regs #(
   parameter int QUE_N = tsq_pkg::QUE_COUNT
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [4:0] addr,
   input wire logic [15:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [15:0] rdata,
   input wire logic copy_hold_cmd,
   input wire logic [1:0] copy_target,
   input wire logic jump_on_counter1_cmd,
   output logic [15:0] counter1_loop_limit_out,
   output logic [15:0] copy_value,
   output logic copy_strobe,
   output logic [7:0] step_byte,
   output logic step_done,
   output logic [4:0] active_step
);
   tsq_pkg::tsq_req_s req;                 // bundled request
   logic [15:0] counter1_loop_limit;       // loop limit
   logic [15:0] general_hold_value;        // hold value
   logic [4:0] step_queue_pointer;         // active step index
   logic [15:0] step_delay_limit;          // extra clocks per step
   logic sequencer_enable;                 // module enable
   logic sequencer_start;                  // start flag
   logic [15:0] step_queue_pair [QUE_N];   // queue storage, no reset
   tsq_pkg::tsq_state_e state;
   tsq_pkg::tsq_state_e next_state;
   logic [4:0] next_qptr;
   logic [15:0] c1_count;                  // counter1 loop counter
   logic delay_load;
   logic delay_done;
   logic [16:0] delay_cycles;

   assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

   // lock while executing steps
   wire locked = sequencer_enable & sequencer_start;
   wire wr_ok = req.wr & ~locked;
   wire hit_c1 = req.addr == tsq_pkg::ADDR_C1_LIMIT;
   wire hit_hold = req.addr == tsq_pkg::ADDR_HOLD;
   wire hit_qptr = req.addr == tsq_pkg::ADDR_QPTR;
   wire hit_sdlim = req.addr == tsq_pkg::ADDR_SDLIM;
   wire hit_ctrl = req.addr == tsq_pkg::ADDR_CTRL;
   wire hit_que = req.addr[4:3] == tsq_pkg::ADDR_QUE_BASE[4:3];
   wire [2:0] que_idx = req.addr[2:0];
   // byte select from pointer: even step low byte, odd step high byte
   wire [15:0] cur_pair = step_queue_pair[step_queue_pointer[3:1]];
   wire [7:0] cur_byte = step_queue_pointer[0] ? cur_pair[15:8] : cur_pair[7:0];
   wire [15:0] rd_mux =
      hit_c1 ? counter1_loop_limit :
      hit_hold ? general_hold_value :
      hit_qptr ? {11'h000, step_queue_pointer} :
      hit_sdlim ? step_delay_limit :
      hit_ctrl ? {14'h0000, sequencer_start, sequencer_enable} :
      hit_que ? step_queue_pair[que_idx] : 16'h0000;
   wire running = locked;

   // delay of limit plus one base clock
   assign delay_cycles = {1'b0, step_delay_limit} + tsq_pkg::STEP_BASE_CLOCKS;

   tsq_delay_cnt #(.W(17)) u_delay (
      .clk(clk),
      .arst_n(arst_n),
      .load(delay_load),
      .count(delay_cycles),
      .done(delay_done)
   );

   // step walker next state
   always_comb begin
      next_state = state;
      next_qptr = step_queue_pointer;
      delay_load = 1'b0;
      case (state)
         tsq_pkg::TSQ_IDLE: begin
            if (running) begin
               delay_load = 1'b1;
               next_state = tsq_pkg::TSQ_WAIT;
            end
         end
         tsq_pkg::TSQ_WAIT: begin
            if (!running) begin
               next_state = tsq_pkg::TSQ_IDLE;
            end else if (delay_done) begin
               next_state = tsq_pkg::TSQ_DONE;
            end
         end
         tsq_pkg::TSQ_DONE: begin
            // jump back to step 0 while loops remain, else advance
            if (jump_on_counter1_cmd && c1_count != counter1_loop_limit) begin
               next_qptr = 5'h00;
            end else begin
               next_qptr = step_queue_pointer + 5'h01;
            end
            next_state = running ? tsq_pkg::TSQ_IDLE : tsq_pkg::TSQ_IDLE;
         end
         default: begin
            next_state = tsq_pkg::TSQ_IDLE;
         end
      endcase
   end

   // state register
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state <= tsq_pkg::TSQ_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // counter1 loop counter, cleared when not running
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         c1_count <= 16'h0000;
      end else if (!running) begin
         c1_count <= 16'h0000;
      end else if (state == tsq_pkg::TSQ_DONE && jump_on_counter1_cmd) begin
         c1_count <= (c1_count == counter1_loop_limit) ? 16'h0000 : c1_count + 16'h0001;
      end
   end

   // software-visible limits and hold
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         counter1_loop_limit <= tsq_pkg::RST_C1_LIMIT;
         general_hold_value <= tsq_pkg::RST_HOLD;
         step_delay_limit <= tsq_pkg::RST_SDLIM;
      end else begin
         if (wr_ok && hit_c1) begin
            counter1_loop_limit <= req.wdata;
         end
         if (wr_ok && hit_hold) begin
            general_hold_value <= req.wdata;
         end
         if (wr_ok && hit_sdlim) begin
            step_delay_limit <= req.wdata;
         end else if (copy_hold_cmd && copy_target == 2'b01) begin
            step_delay_limit <= general_hold_value;
         end
      end
   end

   // pointer: software when unlocked, walker when running
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         step_queue_pointer <= tsq_pkg::RST_QPTR;
      end else if (wr_ok && hit_qptr) begin
         step_queue_pointer <= req.wdata[4:0];
      end else if (running) begin
         step_queue_pointer <= next_qptr;
      end
   end

   // control bits, always writable so software can stop the run
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         sequencer_enable <= 1'b0;
         sequencer_start <= 1'b0;
      end else if (req.wr && hit_ctrl) begin
         sequencer_enable <= req.wdata[tsq_pkg::CTRL_EN_BIT];
         sequencer_start <= req.wdata[tsq_pkg::CTRL_START_BIT];
      end
   end

   // queue storage has no reset term at all
   always_ff @(posedge clk) begin
      if (wr_ok && hit_que) begin
         step_queue_pair[que_idx] <= req.wdata;
      end
   end

   // registered outputs and read data
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rdata <= 16'h0000;
         counter1_loop_limit_out <= 16'h0000;
         copy_value <= 16'h0000;
         copy_strobe <= 1'b0;
         step_byte <= 8'h00;
         step_done <= 1'b0;
         active_step <= 5'h00;
      end else begin
         rdata <= req.rd ? rd_mux : 16'h0000;
         counter1_loop_limit_out <= counter1_loop_limit;
         copy_value <= general_hold_value;
         copy_strobe <= copy_hold_cmd;
         step_byte <= cur_byte;
         step_done <= (state == tsq_pkg::TSQ_DONE);
         active_step <= step_queue_pointer;
      end
   end
endmodule : tsq_regs

// ---- inc/tsq_pkg.sv ----
/*
 package for the trigger sequencer step queue register block: register
 indices, field positions, reset values, engine states and carriers.
 assumes a 16-bit register port with one-cycle read latency.
*/
package tsq_pkg;
   // register indices on the plain register port
   localparam logic [4:0] ADDR_C1_LIMIT = 5'h00;   // counter1_loop_limit
   localparam logic [4:0] ADDR_HOLD = 5'h01;       // general_hold_value
   localparam logic [4:0] ADDR_QPTR = 5'h02;       // step_queue_pointer
   localparam logic [4:0] ADDR_SDLIM = 5'h03;      // step_delay_limit
   localparam logic [4:0] ADDR_CTRL = 5'h04;       // enable and start bits
   localparam logic [4:0] ADDR_QUE_BASE = 5'h08;   // step_queue_pair 0..7 at 08..0F
   localparam int QUE_COUNT = 8;                    // number of queue pair registers
   // field positions
   localparam int CTRL_EN_BIT = 0;                  // sequencer_enable
   localparam int CTRL_START_BIT = 1;               // sequencer_start
   localparam int QPTR_W = 5;                       // pointer width
   // reset values
   localparam logic [15:0] RST_C1_LIMIT = 16'h0000;
   localparam logic [15:0] RST_HOLD = 16'h0000;
   localparam logic [4:0] RST_QPTR = 5'h00;
   localparam logic [15:0] RST_SDLIM = 16'h0000;
   // base step delay added to the programmed limit
   localparam logic [16:0] STEP_BASE_CLOCKS = 17'h00001;
   // step engine states
   typedef enum logic [1:0] {
      TSQ_IDLE = 2'b00,
      TSQ_WAIT = 2'b01,
      TSQ_DONE = 2'b10
   } tsq_state_e;
   // one register access request
   typedef struct packed {
      logic [4:0] addr;
      logic [15:0] wdata;
      logic wr;
      logic rd;
   } tsq_req_s;
endpackage : tsq_pkg

// ---- rtl/tsq_delay_cnt.sv ----
/*
 step delay counter: loads a cycle count and pulses done when it runs out.
 assumes load is a one-cycle pulse and the count is at least one.
*/
`timescale 1ns/10ps
module tsq_delay_cnt #(
   parameter int W = 17
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic load,
   input wire logic [W-1:0] count,
   output logic done
);
   logic [W-1:0] remain;   // cycles still to run
   logic busy;             // counter is running

   // count down from load, pulse done on the last cycle
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         remain <= '0;
         busy <= 1'b0;
         done <= 1'b0;
      end else if (load) begin
         remain <= count;
         busy <= 1'b1;
         done <= 1'b0;
      end else if (busy) begin
         remain <= remain - W'(1);
         busy <= (remain != W'(1));
         done <= (remain == W'(1));
      end else begin
         done <= 1'b0;
      end
   end
endmodule : tsq_delay_cnt

// ---- sim/tsq_checker.sv ----
/* port checker for tsq_regs: read timing, lock, copy, step pacing.
 assumes one clock domain and the async active-low reset. */
`timescale 1ns/10ps
module tsq_checker #(
   parameter int QUE_N = tsq_pkg::QUE_COUNT
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [4:0] addr,
   input wire logic [15:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [15:0] rdata,
   input wire logic copy_hold_cmd,
   input wire logic [15:0] counter1_loop_limit_out,
   input wire logic [15:0] copy_value,
   input wire logic copy_strobe,
   input wire logic step_done
);
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   logic [1:0] ctrl; // shadow of enable and start
   logic [15:0] hold; // shadow of hold value
   wire logic run = &ctrl; // registers locked
   // shadow control and hold from software writes
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ctrl <= 2'h0;
         hold <= 16'h0000;
      end else begin
         if (wr && addr == tsq_pkg::ADDR_CTRL) ctrl <= wdata[1:0];
         if (wr && addr == tsq_pkg::ADDR_HOLD && !run) hold <= wdata;
      end
   end
   a_rdata_idle_zero: assert property (!rd |=> rdata == 16'h0000)
      else $error("read data not zero outside a read");
   a_unmapped_zero: assert property (rd && addr == 5'h05 |=> rdata == 16'h0000)
      else $error("unmapped read not zero");
   a_ptr_upper_zero: assert property (rd && addr == tsq_pkg::ADDR_QPTR |=> rdata[15:5] == 11'h000)
      else $error("pointer upper bits not zero");
   a_limit_write_lands: assert property (wr && addr == tsq_pkg::ADDR_C1_LIMIT && !run |->
      ##2 counter1_loop_limit_out == $past(wdata, 2)) else $error("limit write lost");
   a_locked_limit_kept: assert property (wr && addr == tsq_pkg::ADDR_C1_LIMIT && run |->
      ##2 $stable(counter1_loop_limit_out)) else $error("locked limit changed");
   a_copy_hold_value: assert property (copy_hold_cmd |=> copy_strobe && copy_value == $past(hold))
      else $error("copy did not carry hold value");
   a_step_done_spacing: assert property (step_done |=> (!step_done) [*2])
      else $error("step completions too close");
   a_stopped_quiet: assert property ((!run) [*4] |-> !step_done)
      else $error("step completed while stopped");
   c_locked_write: cover property (wr && run);
   c_copy: cover property (copy_hold_cmd);
   c_step: cover property (step_done);
endmodule : tsq_checker
bind tsq_regs tsq_checker #(.QUE_N(QUE_N)) tsq_checker_i (.clk(clk), .arst_n(arst_n), .addr(addr),
   .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .copy_hold_cmd(copy_hold_cmd),
   .counter1_loop_limit_out(counter1_loop_limit_out), .copy_value(copy_value), .copy_strobe(copy_strobe),
   .step_done(step_done));

// ---- sim/tsq_regs_test.sv ----
/* self-checking bench for tsq_regs: access, queue, lock, copy, pacing.
 assumes the bench drives every input from one 100 MHz clock. */
`timescale 1ns/10ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin fail_count++; \
   $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module tsq_regs_test;
   logic clk = 1'b0; // system clock
   logic arst_n = 1'b0; // reset, active low
   logic [4:0] addr = 5'h00;
   logic [15:0] wdata = 16'h0000;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic copy_hold_cmd = 1'b0; // engine copy pulse
   logic [1:0] copy_target = 2'h1; // step delay limit
   logic jump = 1'b0;
   logic [15:0] rdata;
   logic [7:0] step_byte;
   logic step_done;
   logic [4:0] active_step; // registered pointer
   int fail_count = 0;
   int num_checks = 0;
   int cyc = 0;
   int p0, p3;
   always #5 clk = ~clk;
   tsq_regs tsq_regs_i (.clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .copy_hold_cmd(copy_hold_cmd), .copy_target(copy_target), .jump_on_counter1_cmd(jump),
      .counter1_loop_limit_out(), .copy_value(), .copy_strobe(), .step_byte(step_byte),
      .step_done(step_done), .active_step(active_step));
   task automatic final_report;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : final_report
   // hang guard
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         final_report;
      end
   end
   task automatic wreg(input logic [4:0] a, input logic [15:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wreg
   task automatic rchk(input logic [4:0] a, input logic [15:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 `CHK(rdata, e)
   endtask : rchk
   // cycles to the next completion, bounded
   task automatic wait_done(output int n);
      n = 0;
      do begin
         @(posedge clk);
         #1;
         n++;
      end while (step_done !== 1'b1 && n < 200);
   endtask : wait_done
   initial begin
      repeat (2) @(posedge clk);
      arst_n <= 1'b1;
      rchk(tsq_pkg::ADDR_C1_LIMIT, 16'h0000);
      rchk(tsq_pkg::ADDR_HOLD, 16'h0000);
      rchk(5'h05, 16'h0000);
      wreg(tsq_pkg::ADDR_C1_LIMIT, 16'hA5C3);
      wreg(tsq_pkg::ADDR_HOLD, 16'h0004);
      wreg(tsq_pkg::ADDR_QPTR, 16'hFFFF);
      rchk(tsq_pkg::ADDR_QPTR, 16'h001F);
      rchk(tsq_pkg::ADDR_C1_LIMIT, 16'hA5C3);
      for (int x = 0; x < tsq_pkg::QUE_COUNT; x++)
         wreg(tsq_pkg::ADDR_QUE_BASE + 5'(x), {8'(2 * x + 1), 8'(2 * x)} ^ 16'h8040);
      for (int x = 0; x < tsq_pkg::QUE_COUNT; x++)
         rchk(tsq_pkg::ADDR_QUE_BASE + 5'(x), {8'(2 * x + 1), 8'(2 * x)} ^ 16'h8040);
      wreg(tsq_pkg::ADDR_QPTR, 16'h0003);
      repeat (3) @(posedge clk);
      #1 `CHK(step_byte, 8'h83)
      // locked writes while running
      wreg(tsq_pkg::ADDR_QPTR, 16'h0000);
      wreg(tsq_pkg::ADDR_SDLIM, 16'h0000);
      wreg(tsq_pkg::ADDR_CTRL, 16'h0003);
      wait_done(p0);
      wait_done(p0);
      wreg(tsq_pkg::ADDR_C1_LIMIT, 16'h1111);
      wreg(tsq_pkg::ADDR_HOLD, 16'h2222);
      wreg(tsq_pkg::ADDR_QUE_BASE, 16'h3333);
      wreg(tsq_pkg::ADDR_SDLIM, 16'h0009);
      wreg(tsq_pkg::ADDR_CTRL, 16'h0000);
      rchk(tsq_pkg::ADDR_C1_LIMIT, 16'hA5C3);
      rchk(tsq_pkg::ADDR_HOLD, 16'h0004);
      rchk(tsq_pkg::ADDR_QUE_BASE, 16'h8140);
      rchk(tsq_pkg::ADDR_SDLIM, 16'h0000);
      // longer delay limit, then copy hold into it
      wreg(tsq_pkg::ADDR_SDLIM, 16'h0003);
      wreg(tsq_pkg::ADDR_CTRL, 16'h0003);
      wait_done(p3);
      wait_done(p3);
      `CHK(p3 - p0, 3)
      @(posedge clk);
      copy_hold_cmd <= 1'b1;
      @(posedge clk);
      copy_hold_cmd <= 1'b0;
      wreg(tsq_pkg::ADDR_CTRL, 16'h0000);
      rchk(tsq_pkg::ADDR_SDLIM, 16'h0004);
      // counter-1 jump: two loops back to step 0, third completion advances
      wreg(tsq_pkg::ADDR_QPTR, 16'h0000);
      wreg(tsq_pkg::ADDR_C1_LIMIT, 16'h0002);
      @(posedge clk);
      jump <= 1'b1;
      wreg(tsq_pkg::ADDR_CTRL, 16'h0003);
      repeat (3) wait_done(p0);
      wreg(tsq_pkg::ADDR_CTRL, 16'h0000);
      jump <= 1'b0;
      rchk(tsq_pkg::ADDR_QPTR, 16'h0001);
      `CHK(active_step, 5'h01)
      // queue survives a reset
      @(posedge clk);
      arst_n <= 1'b0;
      repeat (2) @(posedge clk);
      arst_n <= 1'b1;
      rchk(tsq_pkg::ADDR_QUE_BASE + 5'h07, 16'h8F4E);
      rchk(tsq_pkg::ADDR_C1_LIMIT, 16'h0000);
      final_report;
   end
endmodule : tsq_regs_test
